// [parallel_port_pkg.sv]
// Constants, register map and types of the parallel video data port
package parallel_port_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 16;
    localparam int REG_W    = 32;
    localparam int FS_N     = 3;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_DELAY  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_COUNT  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LINES  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;

    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_EN     = 0;
    localparam int CTRL_MODE   = 1;
    localparam int CTRL_VMODE  = 3;
    localparam int CTRL_VTX    = 5;
    localparam int CTRL_NSYNC  = 6;
    localparam int CTRL_WIDTH  = 8;
    localparam int CTRL_FSDIR  = 11;

    localparam logic [1:0] MODE_GP_IN   = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_GP_OUT  = 2'h2;
    localparam logic [1:0] MODE_VIDEO   = 2'h3;

    localparam logic [1:0] VMODE_ACTIVE = 2'h0;
    localparam logic [1:0] VMODE_VBI    = 2'h1;
    localparam logic [1:0] VMODE_ENTIRE = 2'h2;

    localparam logic [1:0] NSYNC_TWO    = 2'h2;
    localparam logic [1:0] NSYNC_THREE  = 2'h3;
    localparam logic [2:0] WIDTH_8      = 3'h0;
    localparam logic [2:0] WIDTH_TOP    = 3'h7;

    // ****************************************
    // Status fields
    // ****************************************
    localparam int STAT_BUSY     = 0;
    localparam int STAT_SYNCED   = 1;
    localparam int STAT_UNDERRUN = 2;
    localparam int STAT_FS       = 4;
    localparam int STAT_PHASE    = 8;

    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] LINES_RESET = 16'h0001;
    localparam logic [DATA_W-1:0] ONE16       = 16'h0001;
    localparam logic [DATA_W-1:0] MASK_8      = 16'h00FF;
    localparam logic [DATA_W-1:0] MASK_16     = 16'hFFFF;
    localparam logic [FS_N-1:0]   FS_ONE      = 3'h1;
    localparam logic [FS_N-1:0]   FS_TWO      = 3'h3;
    localparam logic [FS_N-1:0]   FS_ALL      = 3'h7;

    // ****************************************
    // Embedded preamble
    // ****************************************
    localparam logic [7:0] PRE_FF = 8'hFF;
    localparam logic [7:0] PRE_00 = 8'h00;
    localparam int XY_F = 6;
    localparam int XY_V = 5;
    localparam int XY_H = 4;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_WAIT = 3'b001,
        PH_DATA = 3'b010,
        PH_SYNC = 3'b100
    } phase_type;

endpackage

// [parallel_port.sv]
// Parallel video data port: pin sampling, sequencing, preamble decode, registers
`timescale 1ns/100ps
`default_nettype none

module parallel_port
    import parallel_port_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [REG_W-1:0]  wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output var  logic [REG_W-1:0]  rdata,
    // Port pins
    input  wire logic              port_clock,
    input  wire logic [FS_N-1:0]   frame_sync_in,
    output var  logic [FS_N-1:0]   frame_sync_out,
    output var  logic [FS_N-1:0]   frame_sync_oe_n,
    input  wire logic [DATA_W-1:0] data_in,
    output var  logic [DATA_W-1:0] data_out,
    output var  logic              data_oe_n,
    // Memory side
    output var  logic [DATA_W-1:0] rx_data,
    output var  logic              rx_valid,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output var  logic              tx_ready
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0]            ctrl;
        logic [DATA_W-1:0]            dly;
        logic [DATA_W-1:0]            cnt;
        logic [DATA_W-1:0]            lines;
        logic                         clk_s1;
        logic                         clk_s2;
        logic                         clk_s3;
        logic [FS_N-1:0]              fs_s1;
        logic [FS_N-1:0]              fs_s2;
        logic [FS_N-1:0]              fs_prev;
        logic [DATA_W-1:0]            d_s1;
        logic [DATA_W-1:0]            d_s2;
        phase_type                    phase;
        logic [DATA_W-1:0]            tmr;
        logic [DATA_W-1:0]            smp;
        logic [DATA_W-1:0]            ln;
        logic [2:0][DATA_W-1:0]       pd;
        logic [2:0]                   pv;
        logic                         vact;
        logic                         synced;
        logic                         last_f;
        logic [DATA_W-1:0]            rx_data;
        logic                         rx_valid;
        logic [DATA_W-1:0]            tx_hold;
        logic                         tx_full;
        logic                         tx_ready;
        logic                         underrun;
        logic [DATA_W-1:0]            dout;
        logic                         doe_n;
        logic [FS_N-1:0]              fs_out;
        logic [FS_N-1:0]              fs_oe_n;
        logic [REG_W-1:0]             rdata;
    } state_type;

    state_type         st;
    state_type         n;

    logic              pe;
    logic              en;
    logic [1:0]        md;
    logic [1:0]        vm;
    logic              vtx;
    logic [1:0]        nsync;
    logic [2:0]        wcode;
    logic              w8;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] s;
    logic [7:0]        t;
    logic              xy;
    logic              fs_rise;
    logic [FS_N-1:0]   gen_mask;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] top8(input logic [DATA_W-1:0] x, input logic w);
        top8 = w ? x[7:0] : x[9:2];
    endfunction

    assign en    = st.ctrl[CTRL_EN];
    assign md    = st.ctrl[CTRL_MODE +: 2];
    assign vm    = st.ctrl[CTRL_VMODE +: 2];
    assign vtx   = st.ctrl[CTRL_VTX];
    assign nsync = st.ctrl[CTRL_NSYNC +: 2];
    assign wcode = st.ctrl[CTRL_WIDTH +: 3];
    assign w8    = (wcode == WIDTH_8);
    // Width select, 8 or 10..16
    assign wmask = w8 ? MASK_8 : (MASK_16 >> (WIDTH_TOP - wcode));
    // Port clock rising edge from the synchronised copy
    assign pe    = st.clk_s2 & ~st.clk_s3;
    assign s     = st.d_s2 & wmask;
    assign t     = top8(s, w8);
    // Preamble: FF 00 00 in pipeline, current word is the code
    assign xy    = (&st.pv) && (top8(st.pd[2], w8) == PRE_FF)
                   && (top8(st.pd[1], w8) == PRE_00)
                   && (top8(st.pd[0], w8) == PRE_00);
    assign fs_rise = st.fs_s2[0] & ~st.fs_prev[0];

    // Syncs that the generator drives
    always_comb begin
        gen_mask = '0;
        if (md == MODE_CAPTURE) begin
            gen_mask = FS_TWO;
        end else if (md == MODE_GP_OUT) begin
            case (nsync)
                NSYNC_TWO:   gen_mask = FS_TWO;
                NSYNC_THREE: gen_mask = FS_ALL;
                default:     gen_mask = FS_ONE;
            endcase
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic              rx_take;
        logic [DATA_W-1:0] rx_word;
        logic              tx_take;
        logic              pass;
        logic              line_end;
        logic [DATA_W-1:0] stat;
        rx_take  = 1'b0;
        rx_word  = s;
        tx_take  = 1'b0;
        pass     = 1'b0;
        line_end = 1'b0;
        stat     = '0;
        n = st;
        n.rx_valid = 1'b0;
        n.rdata = '0;

        // Pin synchronisers
        n.clk_s1 = port_clock;
        n.clk_s2 = st.clk_s1;
        n.clk_s3 = st.clk_s2;
        n.fs_s1 = frame_sync_in;
        n.fs_s2 = st.fs_s1;
        n.d_s1 = data_in;
        n.d_s2 = st.d_s1;

        // Register writes
        if (wr) begin
            case (addr)
                ADDR_CTRL:  n.ctrl = wdata[DATA_W-1:0];
                ADDR_DELAY: n.dly = wdata[DATA_W-1:0];
                ADDR_COUNT: n.cnt = wdata[DATA_W-1:0];
                ADDR_LINES: n.lines = wdata[DATA_W-1:0];
                ADDR_STATUS: begin
                    if (wdata[STAT_UNDERRUN]) begin
                        n.underrun = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Register reads
        stat[STAT_BUSY] = (st.phase != PH_IDLE) | st.synced;
        stat[STAT_SYNCED] = st.synced;
        stat[STAT_UNDERRUN] = st.underrun;
        stat[STAT_FS +: FS_N] = st.fs_s2;
        stat[STAT_PHASE +: 3] = st.phase;
        if (rd) begin
            case (addr)
                ADDR_CTRL:   n.rdata = {16'h0000, st.ctrl};
                ADDR_DELAY:  n.rdata = {16'h0000, st.dly};
                ADDR_COUNT:  n.rdata = {16'h0000, st.cnt};
                ADDR_LINES:  n.rdata = {16'h0000, st.lines};
                ADDR_STATUS: n.rdata = {16'h0000, stat};
                default:     n.rdata = '0;
            endcase
        end

        // Transmit holding word
        if (tx_valid && !st.tx_full) begin
            n.tx_hold = tx_data;
            n.tx_full = 1'b1;
        end

        if (!en) begin
            n.phase = PH_IDLE;
            n.synced = 1'b0;
            n.vact = 1'b0;
            n.pv = '0;
            n.ln = '0;
            n.fs_out = '0;
        end else if (pe) begin
            n.fs_prev = st.fs_s2;
            case (md)
                MODE_GP_IN: begin
                    case (st.phase)
                        PH_IDLE: begin
                            n.smp = '0;
                            if (fs_rise) begin
                                if (st.dly == '0) begin
                                    n.phase = PH_DATA;
                                end else begin
                                    n.phase = PH_WAIT;
                                    n.tmr = st.dly;
                                end
                            end
                        end
                        PH_WAIT: begin
                            n.tmr = st.tmr - ONE16;
                            if (st.tmr == ONE16) begin
                                n.phase = PH_DATA;
                            end
                        end
                        PH_DATA: begin
                            rx_take = 1'b1;
                            n.smp = st.smp + ONE16;
                            if (n.smp == st.cnt) begin
                                n.phase = PH_IDLE;
                            end
                        end
                        default: n.phase = PH_IDLE;
                    endcase
                end
                MODE_CAPTURE, MODE_GP_OUT: begin
                    case (st.phase)
                        PH_IDLE: begin
                            n.ln = '0;
                            n.fs_out = FS_TWO;
                            n.phase = PH_SYNC;
                        end
                        PH_SYNC: begin
                            n.fs_out = '0;
                            n.smp = '0;
                            if (st.dly == '0) begin
                                n.phase = PH_DATA;
                                n.fs_out[2] = 1'b1;
                            end else begin
                                n.phase = PH_WAIT;
                                n.tmr = st.dly;
                            end
                        end
                        PH_WAIT: begin
                            n.tmr = st.tmr - ONE16;
                            if (st.tmr == ONE16) begin
                                n.phase = PH_DATA;
                                n.fs_out[2] = 1'b1;
                            end
                        end
                        PH_DATA: begin
                            if (md == MODE_CAPTURE) begin
                                rx_take = 1'b1;
                            end else begin
                                tx_take = 1'b1;
                            end
                            n.smp = st.smp + ONE16;
                            line_end = (n.smp == st.cnt);
                        end
                        default: n.phase = PH_IDLE;
                    endcase
                    if (line_end) begin
                        n.phase = PH_SYNC;
                        n.ln = st.ln + ONE16;
                        if (n.ln == st.lines) begin
                            n.ln = '0;
                        end
                        n.fs_out = {1'b0, (n.ln == '0), 1'b1};
                    end
                end
                MODE_VIDEO: begin
                    if (vtx) begin
                        tx_take = 1'b1;
                    end else begin
                        pass = (vm == VMODE_ENTIRE) ? st.synced : st.vact;
                        if (st.pv[2] && pass && !(xy && vm != VMODE_ENTIRE)) begin
                            rx_take = 1'b1;
                            rx_word = st.pd[2];
                        end
                        n.pd = {st.pd[1:0], s};
                        n.pv = {st.pv[1:0], 1'b1};
                        if (xy) begin
                            if (vm != VMODE_ENTIRE) begin
                                n.pv = '0;
                            end
                            n.last_f = t[XY_F];
                            if (st.last_f && !t[XY_F]) begin
                                n.synced = 1'b1;
                                n.ln = '0;
                            end
                            case (vm)
                                VMODE_ACTIVE: begin
                                    if (t[XY_H] || t[XY_V]) begin
                                        n.vact = 1'b0;
                                    end else if (n.synced && n.ln != st.cnt) begin
                                        n.vact = 1'b1;
                                        n.ln = n.ln + ONE16;
                                    end else begin
                                        n.vact = 1'b0;
                                    end
                                end
                                VMODE_VBI: n.vact = t[XY_V] & n.synced;
                                default:   n.vact = 1'b0;
                            endcase
                        end
                    end
                end
                default: n.phase = PH_IDLE;
            endcase
        end

        // Sample to memory
        if (rx_take) begin
            n.rx_data = rx_word;
            n.rx_valid = 1'b1;
        end

        // Sample to pins, underrun holds last word
        if (tx_take) begin
            if (st.tx_full) begin
                n.dout = st.tx_hold & wmask;
                n.tx_full = 1'b0;
            end else begin
                n.underrun = 1'b1;
            end
        end
        n.tx_ready = ~n.tx_full;

        // Pin directions
        n.fs_out = n.fs_out & (en ? gen_mask : '0);
        n.fs_oe_n = ~(en ? (st.ctrl[CTRL_FSDIR +: FS_N] | gen_mask) : '0);
        n.doe_n = ~(en && (md == MODE_GP_OUT || (md == MODE_VIDEO && vtx)));
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st          <= '0;
            st.ctrl     <= CTRL_RESET;
            st.lines    <= LINES_RESET;
            st.doe_n    <= 1'b1;
            st.fs_oe_n  <= FS_ALL;
            st.tx_ready <= 1'b1;
        end else begin
            st <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata           = st.rdata;
    assign frame_sync_out  = st.fs_out;
    assign frame_sync_oe_n = st.fs_oe_n;
    assign data_out        = st.dout;
    assign data_oe_n       = st.doe_n;
    assign rx_data         = st.rx_data;
    assign rx_valid        = st.rx_valid;
    assign tx_ready        = st.tx_ready;

endmodule // parallel_port

`default_nettype wire

// [parallel_port_sva.sv]
// Assertion checker for the parallel port pins and strobes
`timescale 1ns/100ps
`default_nettype none

module parallel_port_sva
    import parallel_port_pkg::*;
(
    // Clock, reset, bus
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              rd,
    input wire logic [REG_W-1:0]  rdata,
    // Pins
    input wire logic              port_clock,
    input wire logic [FS_N-1:0]   frame_sync_out,
    input wire logic [FS_N-1:0]   frame_sync_oe_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic              data_oe_n,
    // Memory side
    input wire logic              rx_valid,
    input wire logic              tx_valid,
    input wire logic              tx_ready
);
    // ****************************************
    // Cycles since a port clock rise
    // ****************************************
    logic [2:0] pc_reg;
    logic [3:0] age_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_reg  <= 3'h0;
            age_reg <= 4'hF;
        end else begin
            pc_reg  <= {pc_reg[1:0], port_clock};
            age_reg <= (pc_reg[1] && !pc_reg[2]) ? 4'h0 :
                       ((age_reg == 4'hF) ? age_reg : age_reg + 4'h1);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence near_pe_s;
        age_reg <= 4'h6;
    endsequence
    sequence tx_take_s;
        tx_valid && tx_ready;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    rdata_idle_a: assert property (!$past(rd) |-> rdata == '0)
        else $error("rdata not idle");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid too long");
    rx_pe_a: assert property (rx_valid |-> near_pe_s)
        else $error("rx_valid off port edge");
    tx_take_a: assert property (tx_take_s |=> !tx_ready)
        else $error("tx_ready stayed high");
    tx_refill_a: assert property ($rose(tx_ready) |-> near_pe_s)
        else $error("tx_ready off port edge");
    dout_pe_a: assert property ($changed(data_out) && !data_oe_n
        && !$past(data_oe_n) |-> near_pe_s) else $error("data_out off port edge");
    fs_pe_a: assert property ($changed(frame_sync_out) && $stable(frame_sync_oe_n)
        && frame_sync_oe_n != FS_ALL |-> near_pe_s) else $error("sync off edge");
    fs_field_a: assert property ($rose(frame_sync_out[1]) && !frame_sync_oe_n[1]
        |-> frame_sync_out[0]) else $error("field sync without line sync");
    fs_line_a: assert property ($rose(frame_sync_out[0]) && !frame_sync_oe_n[0]
        |=> frame_sync_out[0]) else $error("line sync too short");
endmodule // parallel_port_sva

bind parallel_port parallel_port_sva u_parallel_port_sva (
    .clk, .resetn, .rd, .rdata, .port_clock, .frame_sync_out, .frame_sync_oe_n,
    .data_out, .data_oe_n, .rx_valid, .tx_valid, .tx_ready
);
`default_nettype wire

// [pixel_source.sv]
// Model of the external converter driving port clock, sync one and data
`timescale 1ns/100ps
`default_nettype none

module pixel_source
    import parallel_port_pkg::*;
(
    // Bench control
    input  wire logic              run,
    input  wire logic              sync_req,
    // Pins
    output var  logic              port_clock,
    output var  logic              sync_one,
    output var  logic [DATA_W-1:0] data_pins,
    output var  logic [DATA_W-1:0] mark
);
    initial begin
        port_clock = 1'b0;
        sync_one   = 1'b0;
        data_pins  = 16'hF100;
        mark       = 16'h0000;
        #1;
        forever begin
            #62.5;
            if (run || port_clock) begin
                port_clock = ~port_clock;
                if (!port_clock) begin
                    data_pins = data_pins + 16'h0001;
                    if (sync_req && !sync_one) mark = data_pins;
                    sync_one = sync_req;
                end
            end
        end
    end
endmodule // pixel_source
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the parallel port
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import parallel_port_pkg::*;
    logic              clk, resetn, wr, rd, run, sync_req, tx_valid, chk_on, field_seen;
    logic              port_clock, sync_one, rx_valid, data_oe_n, tx_ready;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata, rdata, v;
    logic [FS_N-1:0]   fs_in, fs_out, fs_oe_n;
    logic [DATA_W-1:0] data_pins, mark, data_out, rx_data, tx_data, mask;
    logic [2:0]        wsel [3];
    logic [DATA_W-1:0] wmsk [3];
    int                fail_count, n_checks, seen, i;

    assign fs_in[0]   = fs_oe_n[0] ? sync_one : fs_out[0];
    assign fs_in[2:1] = fs_out[2:1] & ~fs_oe_n[2:1];

    parallel_port u_parallel_port (
        .clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .port_clock,
        .frame_sync_in(fs_in), .frame_sync_out(fs_out), .frame_sync_oe_n(fs_oe_n),
        .data_in(data_oe_n ? data_pins : data_out), .data_out, .data_oe_n,
        .rx_data, .rx_valid, .tx_data, .tx_valid, .tx_ready
    );
    pixel_source u_pixel_source (.run, .sync_req, .port_clock, .sync_one, .data_pins, .mark);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [REG_W-1:0] got, input logic [REG_W-1:0] want);
        n_checks++;
        if (got !== want) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_seen(input int n);
        for (int k = 0; k < 4000 && seen < n; k++) @(posedge clk);
        if (seen < n) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    task automatic tx_word(input logic [DATA_W-1:0] w);
        tx_data  <= w;
        tx_valid <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b0;
        #1;
        for (int k = 0; k < 100 && tx_ready !== 1'b1; k++) @(posedge clk);
        if (tx_ready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        #1;
    endtask

    // ****************************************
    // Sample monitor
    // ****************************************
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (chk_on) check({16'h0, rx_data}, {16'h0, (mark + 16'h3 + seen[15:0]) & mask});
            seen = seen + 1;
        end
        if (fs_out[1] === 1'b1 && fs_oe_n[1] === 1'b0) field_seen = 1'b1;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {resetn, wr, rd, run, sync_req, tx_valid, chk_on, field_seen} = 8'h00;
        {addr, wdata, tx_data, mask} = '0;
        {fail_count, n_checks, seen} = '0;
        wsel = '{3'h0, 3'h3, 3'h7};
        wmsk = '{16'h00FF, 16'h0FFF, 16'hFFFF};
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(ADDR_CTRL);  check(v, 32'h0);
        rd_reg(ADDR_LINES); check(v, 32'h1);
        rd_reg(8'h20);      check(v, 32'h0);
        wr_reg(ADDR_DELAY, 32'hABCD0002);
        rd_reg(ADDR_DELAY); check(v, 32'h2);
        wr_reg(ADDR_COUNT, 32'h3);
        run <= 1'b1;
        // Input submode at 8, 12 and 16 bits
        for (i = 0; i < 3; i++) begin
            wr_reg(ADDR_CTRL, {18'h0, 3'h4, wsel[i], 8'h01});
            mask = wmsk[i];
            seen = 0;
            chk_on = 1'b1;
            repeat (30) @(posedge clk);
            check({29'h0, fs_oe_n}, 32'h3);
            sync_req <= 1'b1;
            wait_seen(3);
            repeat (400) @(posedge clk);
            check(seen, 3);
            sync_req <= 1'b0;
            wr_reg(ADDR_CTRL, 32'h0);
        end
        // Frame capture
        chk_on = 1'b0;
        seen = 0;
        wr_reg(ADDR_DELAY, 32'h1);
        wr_reg(ADDR_LINES, 32'h2);
        wr_reg(ADDR_CTRL, 32'h703);
        wait_seen(6);
        check({28'h0, fs_oe_n, data_oe_n}, 32'h9);
        check(field_seen, 1);
        wr_reg(ADDR_CTRL, 32'h0);
        // Output with three syncs
        wr_reg(ADDR_CTRL, 32'h7C5);
        tx_word(16'hA5C3);
        check({15'h0, data_oe_n, data_out}, 32'hA5C3);
        check({29'h0, fs_oe_n}, 32'h0);
        repeat (40) @(posedge clk);
        rd_reg(ADDR_STATUS); check(v & 32'h4, 32'h4);
        wr_reg(ADDR_CTRL, 32'h0);
        wr_reg(ADDR_STATUS, 32'h4);
        rd_reg(ADDR_STATUS); check(v & 32'h4, 32'h0);
        // Video transmit at 8 bits
        wr_reg(ADDR_CTRL, 32'h27);
        tx_word(16'h5A3C);
        check({15'h0, data_oe_n, data_out}, 32'h3C);
        check({29'h0, fs_oe_n}, 32'h7);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
